// file: rtl/itr_irq_bank.sv
// Purpose: Sticky handoff status with clear, force and enable gating.
// Assumes: Strobes are single-cycle from the register port.
// Notes: Reserved bit 4 never sets.
`timescale 1ns/1ps
`default_nettype none
module itr_irq_bank (
    input wire logic clk,
    input wire logic rst,
    itr_irq_if.bank bus
);
    // ==========================================================
    // Status storage
    logic [7:0] status_ff;
    logic [7:0] nxt_status;
    logic [7:0] setAll;

    // Hardware events and software force both set a bit
    assign setAll = (bus.hwSet | bus.force1) & itr_pkg::IRQ_VALID_MASK;
    // Set wins over a clear in the same cycle, so no event is lost
    assign nxt_status = (status_ff & ~bus.w1c) | setAll;

    // Sticky bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= itr_pkg::BYTE_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    assign bus.status = status_ff;
    // R17: enable gating
    assign bus.irq = |(status_ff & bus.enable);
endmodule // itr_irq_bank
`default_nettype wire

// file: rtl/itr_irq_if.sv
// Purpose: Carries handoff status events between the bank and its owner.
// Assumes: Same clock on both sides.
// Notes: All vectors use the status bit layout.
`timescale 1ns/1ps
`default_nettype none
interface itr_irq_if;
    logic [7:0] hwSet;   // Hardware event pulses
    logic [7:0] w1c;     // Software clear strobes
    logic [7:0] force1;  // Software force strobes
    logic [7:0] enable;  // Interrupt enables
    logic [7:0] status;  // Sticky status
    logic irq;           // Combined interrupt
    modport bank (input hwSet, w1c, force1, enable, output status, irq);
    modport owner (output hwSet, w1c, force1, enable, input status, irq);
endinterface
`default_nettype wire

// file: rtl/itr_pkg.sv
// Purpose: Shared constants for the controller-role register bank.
// Assumes: Single 100 MHz clock, byte-wide register port.
// Notes: Offsets are register-space byte offsets before relocation.
`default_nettype none
package itr_pkg;
    // ====================
    // Register offsets
    localparam logic [6:0] OFF_EVT_CAP = 7'h04;
    localparam logic [6:0] OFF_EVT_REQ = 7'h05;
    localparam logic [6:0] OFF_MAX_WR = 7'h0c;
    localparam logic [6:0] OFF_CAPS_B3 = 7'h1a;
    localparam logic [6:0] OFF_IRQ_STAT = 7'h39;
    localparam logic [6:0] OFF_IRQ_EN = 7'h3a;
    localparam logic [6:0] OFF_IRQ_SET = 7'h3b;
    localparam logic [6:0] OFF_ANN_CNT = 7'h40;
    localparam logic [6:0] OFF_ANN_START = 7'h41;
    localparam logic [6:0] OFF_ANN_BYTES = 7'h42;
    localparam logic [6:0] OFF_HANDOFF = 7'h43;
    // ====================
    // Field positions
    localparam int BIT_HJ = 3;
    localparam int BIT_CR = 1;
    localparam int BIT_IBI = 0;
    localparam int BIT_DEFBYTE = 3;
    localparam int BIT_PEND_RD = 6;
    localparam int BIT_AUTO_RESP = 7;
    localparam int ST_ACCCR_RCVD = 7;
    localparam int ST_ACCCR_NACK = 6;
    localparam int ST_ANN_RCVD = 5;
    localparam int ST_CR_GEN = 3;
    localparam int ST_CR_DONE = 2;
    localparam int ST_CR_REFUSED = 1;
    localparam int ST_ROLE_CHG = 0;
    // ====================
    // Fixed values and reset values
    localparam logic [7:0] IRQ_VALID_MASK = 8'hef;
    localparam logic [7:0] CAPS_B3_FIXED = 8'h1c;
    localparam logic [2:0] RATE_RESET = 3'h0;
    localparam logic [2:0] RATE_MAX_CODE = 3'h4;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic AUTO_RESP_RESET = 1'b1;
    // ====================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int BUS_FREE_NS = 1000;
    localparam int BUS_FREE_CYC = (BUS_FREE_NS * CLK_MHZ) / 1000;
    localparam int HANDOFF_WAIT_US = 100;
    localparam int HANDOFF_WAIT_CYC = HANDOFF_WAIT_US * CLK_MHZ;
    // Role monitor states
    typedef enum logic [1:0] {ROLE_IDLE, ROLE_WATCH, ROLE_ASSERT} itr_role_t;
endpackage
`default_nettype wire

// file: rtl/itr_role_regs.sv
// Purpose: Register bank for events, speed, caps and role handoff.
// Assumes: Protocol engine on clk supplies event pulses; SCL/SDA async.
// Notes: Register port is a plain byte port, read data registered.
//
// Operation
// R1: Hot-join request bit, cleared when done/disabled
// R2: Role request bit, cleared when done/disabled
// R3: Interrupt request bit, cleared when done/disabled
// R4: Capability bits reflect build options
// R5: Three-bit writable maximum write rate code
// R6: Speed-query defining byte bit fixed one; code drives it from SC_CAP
// R7: Pending-read bit set with mandatory-byte interrupts
// R8: Byte three fixed defining-byte and unsupported bits
// R9: Status 7 sets on role-accept query
// R10: Status 6 sets when that query NACKed
// R11: Status 5 sets after full announce broadcast
// R12: Status 3 sets on role request generated
// R13: Status 2 sets on role request finished
// R14: Status 1 sets on role request refused
// R15: Role passed; cancel if new controller silent
// R16: Role taken; assert per auto-assert setting
// R17: Enable bits gate status onto interrupt
// R18: Force register sets status, write-only
// R19: Announced device count captured read-only
// R20: Start pointer counts reads before announce data
// R21: Byte count drops per read after start
// R22: Auto reply bit resets one; one means NACK
// R23: Register space relocated with MSB in secondary build
// R24: Start pointer decrements per read until zero
`timescale 1ns/1ps
`default_nettype none
module itr_role_regs #(
    parameter bit HOT_JOIN_CAPABLE = 1'b1,       // Hot-join built in
    parameter bit SC_CAP = 1'b1,       // Secondary-controller built in
    parameter bit IBI_CAP = 1'b1,      // In-band interrupt built in
    parameter bit IBI_MDB = 1'b1,      // Interrupt carries a data byte
    parameter int HANDOFF_WAIT = itr_pkg::HANDOFF_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    // Bus lines, sampled only
    input wire logic sclIn,
    input wire logic sdaIn,
    // Requests to the protocol engine
    output logic hotJoinRequest,
    output logic roleRequest,
    output logic ibiRequest,
    // Engine completion and disable pulses
    input wire logic hotJoinDone,
    input wire logic hotJoinDisabled,
    input wire logic roleReqDone,
    input wire logic roleReqDisabled,
    input wire logic ibiDone,
    input wire logic ibiDisabled,
    // Engine handoff events
    input wire logic getAcccrSeen,
    input wire logic announceDone,
    input wire logic roleRequestGenerated,
    input wire logic roleRequestFinished,
    input wire logic roleRequestRefused,
    input wire logic roleChanged,
    input wire logic roleChangedTo,
    input wire logic newCtrlAsserted,
    input wire logic autoAssertRole,
    // Announce bookkeeping from the engine
    input wire logic announceLoad,
    input wire logic [7:0] announceCount,
    input wire logic [7:0] announceStart,
    input wire logic [7:0] announceBytes,
    input wire logic rxFifoRead,
    // Results
    output logic getAcccrNack,
    output logic [2:0] maxWriteRateCode,
    output logic deviceRole,
    output logic assertRoleReq,
    output logic intOut
);
    // ==========================================================
    // Helpers

    // Saturating decrement, shared by both announce counters
    function automatic logic [7:0] dec8(input logic [7:0] v);
        dec8 = (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction

    // ==========================================================
    // Link line sampling

    logic [2:0] sclSync_ff;  // Three-stage sampler for SCL
    logic [2:0] sdaSync_ff;  // Three-stage sampler for SDA
    logic sclLvl_ff;         // Accepted SCL level
    logic sdaLvl_ff;         // Accepted SDA level
    logic [7:0] freeCnt_ff;  // Cycles with both lines high
    logic busFree;           // Bus idle long enough for a request

    // Shift the raw lines in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclSync_ff <= 3'h7;
            sdaSync_ff <= 3'h7;
        end else begin
            sclSync_ff <= {sclSync_ff[1:0], sclIn};
            sdaSync_ff <= {sdaSync_ff[1:0], sdaIn};
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclLvl_ff <= 1'b1;
            sdaLvl_ff <= 1'b1;
        end else begin
            if (sclSync_ff[1] == sclSync_ff[2]) begin
                sclLvl_ff <= sclSync_ff[2];
            end
            if (sdaSync_ff[1] == sdaSync_ff[2]) begin
                sdaLvl_ff <= sdaSync_ff[2];
            end
        end
    end

    // Idle timer: a request only goes out on a quiet bus
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freeCnt_ff <= 8'h00;
        end else if (!(sclLvl_ff && sdaLvl_ff)) begin
            freeCnt_ff <= 8'h00;
        end else if (!busFree) begin
            freeCnt_ff <= freeCnt_ff + 8'h01;
        end
    end
    assign busFree = (freeCnt_ff >= 8'(itr_pkg::BUS_FREE_CYC));

    // ==========================================================
    // Address decode

    logic addrSpaceHit;  // MSB matches the build's register space
    logic [6:0] regOff;  // Offset within the space
    logic wrEvtReq;
    logic wrMaxWr;
    logic wrIrqStat;
    logic wrIrqEn;
    logic wrIrqSet;
    logic wrHandoff;

    // R23: relocated space in a secondary build
    assign addrSpaceHit = (regAddr[7] == SC_CAP);
    assign regOff = regAddr[6:0];
    assign wrEvtReq = regWr && addrSpaceHit && (regOff == itr_pkg::OFF_EVT_REQ);
    assign wrMaxWr = regWr && addrSpaceHit && (regOff == itr_pkg::OFF_MAX_WR);
    assign wrIrqStat = regWr && addrSpaceHit && (regOff == itr_pkg::OFF_IRQ_STAT);
    assign wrIrqEn = regWr && addrSpaceHit && (regOff == itr_pkg::OFF_IRQ_EN);
    assign wrIrqSet = regWr && addrSpaceHit && (regOff == itr_pkg::OFF_IRQ_SET);
    assign wrHandoff = regWr && addrSpaceHit && (regOff == itr_pkg::OFF_HANDOFF);

    // ==========================================================
    // Event request bits

    logic hjPend_ff;  // Pending hot-join
    logic crPend_ff;  // Pending role request
    logic ibiReq_ff;  // Pending in-band interrupt

    // Software sets; engine clears; a set only sticks if capable.
    // Software write wins so a fresh request is never dropped.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hjPend_ff <= 1'b0;
            crPend_ff <= 1'b0;
            ibiReq_ff <= 1'b0;
        end else begin
            // R1: hot-join request
            if (wrEvtReq && regWrData[itr_pkg::BIT_HJ] && HOT_JOIN_CAPABLE) begin
                hjPend_ff <= 1'b1;
            end else if (hotJoinDone || hotJoinDisabled) begin
                hjPend_ff <= 1'b0;
            end
            // R2: role request
            if (wrEvtReq && regWrData[itr_pkg::BIT_CR] && SC_CAP) begin
                crPend_ff <= 1'b1;
            end else if (roleReqDone || roleReqDisabled) begin
                crPend_ff <= 1'b0;
            end
            // R3: interrupt request
            if (wrEvtReq && regWrData[itr_pkg::BIT_IBI] && IBI_CAP) begin
                ibiReq_ff <= 1'b1;
            end else if (ibiDone || ibiDisabled) begin
                ibiReq_ff <= 1'b0;
            end
        end
    end

    // Requests wait for a valid opportunity: the idle bus
    assign hotJoinRequest = hjPend_ff && busFree;
    assign roleRequest = crPend_ff && busFree;
    assign ibiRequest = ibiReq_ff && busFree;

    // ==========================================================
    // Speed report and handoff configuration

    logic [2:0] rate_ff;     // Maximum write rate code
    logic autoResp_ff;       // Reply to role-accept query
    logic [7:0] irqEn_ff;    // Interrupt enables

    // Writable configuration fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_ff <= itr_pkg::RATE_RESET;
            autoResp_ff <= itr_pkg::AUTO_RESP_RESET;
            irqEn_ff <= itr_pkg::BYTE_RESET;
        end else begin
            // R5: rate code, all eight codes stored as written
            if (wrMaxWr) begin
                rate_ff <= regWrData[2:0];
            end
            // R22: auto reply select
            if (wrHandoff) begin
                autoResp_ff <= regWrData[itr_pkg::BIT_AUTO_RESP];
            end
            if (wrIrqEn) begin
                irqEn_ff <= regWrData & itr_pkg::IRQ_VALID_MASK;
            end
        end
    end
    assign maxWriteRateCode = rate_ff;
    // R22: one means NACK
    assign getAcccrNack = autoResp_ff;

    // ==========================================================
    // Role handoff monitor

    itr_pkg::itr_role_t roleSt_ff;
    itr_pkg::itr_role_t nxt_roleSt;
    logic role_ff;                // Current role, one is controller
    logic nxt_role;
    logic [23:0] waitCnt_ff;      // Cycles waiting on new controller
    logic [23:0] nxt_waitCnt;
    logic roleRestore;            // Handoff cancelled this cycle

    // Next-state selection for the monitor
    always_comb begin
        nxt_roleSt = roleSt_ff;
        nxt_role = role_ff;
        nxt_waitCnt = waitCnt_ff;
        roleRestore = 1'b0;
        case (roleSt_ff)
            itr_pkg::ROLE_IDLE: begin
                if (roleChanged) begin
                    nxt_role = roleChangedTo;
                    nxt_waitCnt = 24'h000000;
                    // R15: passed away, start watching
                    // R16: taken, go assert
                    nxt_roleSt = roleChangedTo ? itr_pkg::ROLE_ASSERT
                                               : itr_pkg::ROLE_WATCH;
                end
            end
            itr_pkg::ROLE_WATCH: begin
                // R15: cancel on silence
                if (newCtrlAsserted) begin
                    nxt_roleSt = itr_pkg::ROLE_IDLE;
                end else if (waitCnt_ff >= 24'(HANDOFF_WAIT - 1)) begin
                    nxt_role = 1'b1;
                    roleRestore = 1'b1;
                    nxt_roleSt = itr_pkg::ROLE_IDLE;
                end else begin
                    nxt_waitCnt = waitCnt_ff + 24'h000001;
                end
            end
            itr_pkg::ROLE_ASSERT: begin
                // One cycle to hand the assert decision out
                nxt_roleSt = itr_pkg::ROLE_IDLE;
            end
            default: begin
                nxt_roleSt = itr_pkg::ROLE_IDLE;
            end
        endcase
    end

    // Monitor state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            roleSt_ff <= itr_pkg::ROLE_IDLE;
            role_ff <= 1'b0;
            waitCnt_ff <= 24'h000000;
        end else begin
            roleSt_ff <= nxt_roleSt;
            role_ff <= nxt_role;
            waitCnt_ff <= nxt_waitCnt;
        end
    end
    assign deviceRole = role_ff;
    // R16: follow the companion's auto-assert setting
    assign assertRoleReq = (roleSt_ff == itr_pkg::ROLE_ASSERT) && autoAssertRole;

    // ==========================================================
    // Handoff status bank

    itr_irq_if irqBus ();
    logic [7:0] hwEvt;

    // Gather event pulses into status layout
    always_comb begin
        hwEvt = 8'h00;
        // R9: query received
        hwEvt[itr_pkg::ST_ACCCR_RCVD] = getAcccrSeen;
        // R10: query NACKed
        hwEvt[itr_pkg::ST_ACCCR_NACK] = getAcccrSeen && autoResp_ff;
        // R11: full broadcast received
        hwEvt[itr_pkg::ST_ANN_RCVD] = announceDone;
        // R12: request generated
        hwEvt[itr_pkg::ST_CR_GEN] = roleRequestGenerated;
        // R13: request finished
        hwEvt[itr_pkg::ST_CR_DONE] = roleRequestFinished;
        // R14: request refused
        hwEvt[itr_pkg::ST_CR_REFUSED] = roleRequestRefused;
        // Role flips either way, including a cancelled handoff
        hwEvt[itr_pkg::ST_ROLE_CHG] = roleChanged || roleRestore;
    end

    assign irqBus.hwSet = hwEvt;
    assign irqBus.w1c = wrIrqStat ? regWrData : 8'h00;
    // R18: force strobes, nothing stored
    assign irqBus.force1 = wrIrqSet ? regWrData : 8'h00;
    assign irqBus.enable = irqEn_ff;

    itr_irq_bank uIrqBank (
        .clk(clk),
        .rst(rst),
        .bus(irqBus.bank)
    );
    // R17: gated interrupt output
    assign intOut = irqBus.irq;

    // ==========================================================
    // Announce bookkeeping

    logic [7:0] annCnt_ff;    // Devices announced
    logic [7:0] annStart_ff;  // Reads before announce data
    logic [7:0] annBytes_ff;  // Announce bytes still queued

    // Load from the engine wins over a read in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            annCnt_ff <= itr_pkg::BYTE_RESET;
            annStart_ff <= itr_pkg::BYTE_RESET;
            annBytes_ff <= itr_pkg::BYTE_RESET;
        end else if (announceLoad) begin
            // R19: capture count
            annCnt_ff <= announceCount;
            annStart_ff <= announceStart;
            annBytes_ff <= announceBytes;
        end else if (rxFifoRead) begin
            // R24: walk down to the data
            if (annStart_ff != 8'h00) begin
                annStart_ff <= dec8(annStart_ff);
            // R21: consume announce bytes
            end else begin
                annBytes_ff <= dec8(annBytes_ff);
            end
        end
    end

    // ==========================================================
    // Read path

    logic [7:0] rdMux;
    logic [7:0] capByte;
    logic [7:0] reqByte;
    logic [7:0] maxWrByte;
    logic [7:0] capsB3;

    // R4: capability bits
    assign capByte = {4'h0, HOT_JOIN_CAPABLE, 1'b0, SC_CAP, IBI_CAP};
    assign reqByte = {4'h0, hjPend_ff, 1'b0, crPend_ff, ibiReq_ff};
    // R6: defining byte support in speed query
    assign maxWrByte = {4'h0, SC_CAP, rate_ff};
    // R7: pending read, R8: fixed bits
    assign capsB3 = itr_pkg::CAPS_B3_FIXED | {1'b0, IBI_CAP && IBI_MDB, 6'h00};

    // Register select; unmapped and force register read zero
    always_comb begin
        rdMux = 8'h00;
        if (addrSpaceHit) begin
            case (regOff)
                itr_pkg::OFF_EVT_CAP: rdMux = capByte;
                itr_pkg::OFF_EVT_REQ: rdMux = reqByte;
                itr_pkg::OFF_MAX_WR: rdMux = maxWrByte;
                itr_pkg::OFF_CAPS_B3: rdMux = capsB3;
                itr_pkg::OFF_IRQ_STAT: rdMux = irqBus.status;
                itr_pkg::OFF_IRQ_EN: rdMux = irqEn_ff;
                // R20: start pointer
                itr_pkg::OFF_ANN_START: rdMux = annStart_ff;
                itr_pkg::OFF_ANN_CNT: rdMux = annCnt_ff;
                itr_pkg::OFF_ANN_BYTES: rdMux = annBytes_ff;
                itr_pkg::OFF_HANDOFF: rdMux = {autoResp_ff, 7'h00};
                default: rdMux = 8'h00;
            endcase
        end
    end

    // Read data held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            regRdData <= rdMux;
        end
    end
endmodule // itr_role_regs
`default_nettype wire

// file: verification/itr_engine_model.sv
// Purpose: Engine model, one frame serves all requests pending at its start, then done
// Assumes: Request levels gated by bus idle
// Notes: SCL rests high outside frames
`timescale 1ns/1ps
`default_nettype none
module itr_engine_model (
    input wire logic clk,
    input wire logic hjIn,
    input wire logic crIn,
    input wire logic ibiIn,
    output logic scl,
    output logic sda,
    output logic hjDone,
    output logic crDone,
    output logic ibiDone
);
    logic [2:0] got; // Requests served in this frame
    initial {scl, sda, hjDone, crDone, ibiDone} = 5'h18;
    // ==========
    // Frame: start, nine bits at 125 ns, stop
    always begin
        @(posedge clk iff (hjIn | crIn | ibiIn));
        got = {hjIn, crIn, ibiIn};
        sda = 1'b0;
        repeat (9) begin
            #62.5 scl = 1'b0;
            #62.5 scl = 1'b1;
        end
        sda = 1'b1;
        @(negedge clk);
        {hjDone, crDone, ibiDone} = got;
        @(negedge clk);
        {hjDone, crDone, ibiDone} = 3'h0;
    end
endmodule // itr_engine_model
`default_nettype wire

// file: verification/itr_role_regs_sva.sv
// Purpose: Port checks of the role bank
// Assumes: Default build
// Notes: Bound to every itr_role_regs
`timescale 1ns/1ps
`default_nettype none
module itr_role_regs_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic hotJoinRequest,
    input wire logic roleRequest,
    input wire logic ibiRequest,
    input wire logic hotJoinDone,
    input wire logic roleReqDisabled,
    input wire logic ibiDone,
    input wire logic roleChanged,
    input wire logic roleChangedTo,
    input wire logic autoAssertRole,
    input wire logic getAcccrNack,
    input wire logic [2:0] maxWriteRateCode,
    input wire logic deviceRole,
    input wire logic assertRoleReq,
    input wire logic intOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // A same-cycle software set wins
    wire reqWr = regWr && regAddr == 8'h85;
    // Role taken from idle, auto-assert on
    sequence take_s;
        roleChanged && roleChangedTo && autoAssertRole && !deviceRole && !assertRoleReq;
    endsequence
    hj_clear_a: assert property (hotJoinDone && !(reqWr && regWrData[3]) |=> !hotJoinRequest)
        else $error("hot-join request stayed up");
    cr_clear_a: assert property (roleReqDisabled && !(reqWr && regWrData[1]) |=> !roleRequest)
        else $error("role request stayed up");
    ibi_clear_a: assert property (ibiDone && !(reqWr && regWrData[0]) |=> !ibiRequest)
        else $error("interrupt request stayed up");
    caps_read_a: assert property (regRd && regAddr == 8'h84 |=> regRdData == 8'h0b)
        else $error("capability bits wrong");
    rate_write_a: assert property (regWr && regAddr == 8'h8c
        |=> maxWriteRateCode == $past(regWrData[2:0]))
        else $error("rate code not taken");
    caps3_read_a: assert property (regRd && regAddr == 8'h9a |=> regRdData == 8'h5c)
        else $error("byte three wrong");
    irq_off_a: assert property (regWr && regAddr == 8'hba && regWrData == 8'h00 |=> !intOut)
        else $error("interrupt with enables off");
    nack_write_a: assert property (regWr && regAddr == 8'hc3
        |=> getAcccrNack == $past(regWrData[7]))
        else $error("auto reply not taken");
    role_take_a: assert property (take_s |-> ##1 assertRoleReq ##1 !assertRoleReq)
        else $error("role assert pulse wrong");
endmodule // itr_role_regs_sva
bind itr_role_regs itr_role_regs_sva chk (.*);
`default_nettype wire

// file: verification/itr_role_regs_tb.sv
// Purpose: Register tests of the role bank
// Assumes: Default build, handoff wait 20
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module itr_role_regs_tb;
    logic clk = 0, rst = 1, regWr = 0, regRd = 0, roleChangedTo = 0, autoAssertRole = 1;
    logic [7:0] regAddr = 0, regWrData = 0, aCnt = 0, aStart = 0, aBytes = 0, seen;
    logic [11:0] ev = 0; // One bit per engine event
    logic reqSeen = 0;
    wire logic [7:0] rdData;
    wire logic hjR, crR, ibR, hjD, crD, ibD, scl, sda, nack, role, arr, irq;
    wire logic [2:0] rate;
    int errors = 0, n_compared = 0, cyc = 0;
    always #5 clk = ~clk;
    itr_role_regs #(.HANDOFF_WAIT(20)) dut (.clk(clk), .rst(rst), .regAddr(regAddr),
        .regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData(rdData),
        .sclIn(scl), .sdaIn(sda), .hotJoinRequest(hjR), .roleRequest(crR), .ibiRequest(ibR),
        .hotJoinDone(hjD), .hotJoinDisabled(ev[10]), .roleReqDone(crD),
        .roleReqDisabled(ev[9]), .ibiDone(ibD), .ibiDisabled(ev[11]), .getAcccrSeen(ev[0]),
        .announceDone(ev[1]), .roleRequestGenerated(ev[2]), .roleRequestFinished(ev[3]),
        .roleRequestRefused(ev[4]), .roleChanged(ev[5]), .roleChangedTo(roleChangedTo),
        .newCtrlAsserted(ev[6]), .autoAssertRole(autoAssertRole), .announceLoad(ev[7]),
        .announceCount(aCnt), .announceStart(aStart), .announceBytes(aBytes),
        .rxFifoRead(ev[8]), .getAcccrNack(nack), .maxWriteRateCode(rate),
        .deviceRole(role), .assertRoleReq(arr), .intOut(irq));
    itr_engine_model eng (.clk(clk), .hjIn(hjR), .crIn(crR), .ibiIn(ibR), .scl(scl),
        .sda(sda), .hjDone(hjD), .crDone(crD), .ibiDone(ibD));
    // All three requests reached the engine
    always @(posedge clk) if (hjR & crR & ibR) reqSeen <= 1'b1;
    // ==========
    // Tasks
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk); regAddr = a; regWrData = d; regWr = 1;
        @(negedge clk); regWr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk); regAddr = a; regRd = 1;
        @(negedge clk); regRd = 0;
        @(negedge clk); chk($sformatf("reg %h", a), rdData, exp);
    endtask
    task pulse(input logic [11:0] m);
        @(negedge clk); ev = m;
        @(negedge clk); ev = 0;
    endtask
    task tally_and_finish();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    // ==========
    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        rst = 0;
        rd(8'h84, 8'h0b);
        rd(8'h8c, 8'h08);
        rd(8'h9a, 8'h5c);
        rd(8'hc3, 8'h80);
        rd(8'hc0, 8'h00);
        rd(8'h05, 8'h00);
        wr(8'h0c, 8'h07);
        rd(8'h8c, 8'h08);
        for (int i = 0; i < 5; i++) begin
            wr(8'h8c, i[7:0]);
            rd(8'h8c, 8'h08 | i[7:0]);
        end
        // Requests go out on an idle bus
        repeat (100) @(negedge clk);
        wr(8'h85, 8'h0b);
        rd(8'h85, 8'h0b);
        repeat (300) @(negedge clk);
        rd(8'h85, 8'h00);
        chk("reqSeen", {7'h0, reqSeen}, 8'h01);
        wr(8'h85, 8'h0b);
        pulse(12'he00);
        rd(8'h85, 8'h00);
        repeat (300) @(negedge clk);
        // Status, enables, clear, force
        wr(8'hba, 8'hff);
        pulse(12'h01f);
        rd(8'hb9, 8'hee);
        chk("irq", {7'h0, irq}, 8'h01);
        wr(8'hb9, 8'hff);
        rd(8'hb9, 8'h00);
        wr(8'hba, 8'h00);
        wr(8'hbb, 8'hff);
        rd(8'hb9, 8'hef);
        rd(8'hbb, 8'h00);
        chk("irq", {7'h0, irq}, 8'h00);
        wr(8'hb9, 8'hff);
        wr(8'hc3, 8'h00);
        chk("nack", {7'h0, nack}, 8'h00);
        pulse(12'h001);
        rd(8'hb9, 8'h80);
        wr(8'hb9, 8'hff);
        // Announce bookkeeping
        aCnt = 3; aStart = 2; aBytes = 4;
        pulse(12'h080);
        rd(8'hc0, 8'h03);
        for (int k = 0; k < 7; k++) begin
            pulse(12'h100);
            rd(8'hc1, (k == 0) ? 8'h01 : 8'h00);
            rd(8'hc2, (k < 2) ? 8'h04 : (k < 6) ? 8'(5 - k) : 8'h00);
        end
        // Role taken, then passed twice
        roleChangedTo = 1;
        @(negedge clk); ev = 12'h020; seen = 0;
        repeat (3) begin
            @(negedge clk); ev = 0; seen |= {7'h0, arr};
        end
        chk("assert", seen, 8'h01);
        chk("role", {7'h0, role}, 8'h01);
        rd(8'hb9, 8'h01);
        roleChangedTo = 0;
        repeat (5) @(negedge clk);
        pulse(12'h020);
        chk("role", {7'h0, role}, 8'h00);
        repeat (30) @(negedge clk);
        chk("role", {7'h0, role}, 8'h01);
        pulse(12'h020);
        repeat (3) @(negedge clk);
        pulse(12'h040);
        repeat (30) @(negedge clk);
        chk("role", {7'h0, role}, 8'h00);
        tally_and_finish();
    end
endmodule // itr_role_regs_tb
`default_nettype wire
